//--- include/svr_consts.svh
`ifndef SVR_CONSTS_SVH
`define SVR_CONSTS_SVH

// Reference levels count in steps of 12.5 mV; level 0 is off
`define SVR_LVL_W 7
`define SVR_LVL_ZERO 7'h00
`define SVR_LVL_TOP 7'h7c
`define SVR_CODE_OFF 7'h7c

// Boot strap levels: 1.1, 1.0, 0.9, 0.8 V
`define SVR_BOOT_00 7'h58
`define SVR_BOOT_01 7'h50
`define SVR_BOOT_10 7'h48
`define SVR_BOOT_11 7'h40

// Fixed strap levels: 1.4, 1.2, 1.0, 0.8 V
`define SVR_FIX_00 7'h70
`define SVR_FIX_01 7'h60
`define SVR_FIX_10 7'h50
`define SVR_FIX_11 7'h40

// Slew timing
`define SVR_CLK_PERIOD_NS 10
`define SVR_STEP_UV 12500
`define SVR_SLEW_UV_PER_US 3250
`define SVR_SLEW_CYCLES ((`SVR_STEP_UV * 1000 + \
    `SVR_SLEW_UV_PER_US * `SVR_CLK_PERIOD_NS - 1) / \
    (`SVR_SLEW_UV_PER_US * `SVR_CLK_PERIOD_NS))

// Soft-start defaults in cycles: 2 ms interval, 15 us per step
`define SVR_SS_TOTAL_DEFAULT 200000
`define SVR_SS_STEP_DEFAULT 1500

// Counter widths
`define SVR_DWELL_W 16
`define SVR_SS_W 20

// Serial frame: core select, northbridge select, 7 code bits
`define SVR_FRAME_BITS 4'h9
`define SVR_FRAME_W 9
`define SVR_CNT_W 4
`define SVR_FR_CORE 8
`define SVR_FR_NB 7

// Synchroniser bit positions
`define SVR_SYNC_W 7
`define SVR_SY_CLK 0
`define SVR_SY_DAT 1
`define SVR_SY_EN 2
`define SVR_SY_FIX 3
`define SVR_SY_SEL 4
`define SVR_SY_POK 5
`define SVR_SY_REG 6

`endif

//--- include/svr_pkg.sv
`include "svr_consts.svh"

package svr_pkg;

    typedef enum logic [1:0] {
        SVR_IDLE,
        SVR_SOFTSTART,
        SVR_RUN,
        SVR_SHUTDOWN
    } svr_state_e;

    typedef struct packed {
        logic [`SVR_SYNC_W-1:0] meta;
        logic [`SVR_SYNC_W-1:0] stable;
    } svr_sync_s;

    typedef struct packed {
        svr_state_e state;
        logic en_d;
        logic parallel_vid_mode;
        logic pgood;
        logic [`SVR_LVL_W-1:0] hold;
        logic [`SVR_LVL_W-1:0] tgt_core;
        logic [`SVR_LVL_W-1:0] tgt_nb;
        logic [`SVR_LVL_W-1:0] ref_core;
        logic [`SVR_LVL_W-1:0] ref_nb;
        logic [`SVR_DWELL_W-1:0] dwell;
        logic [`SVR_SS_W-1:0] ss_cnt;
        logic clk_d;
        logic dat_d;
        logic rx_on;
        logic [`SVR_FRAME_W-1:0] rx_sh;
        logic [`SVR_CNT_W-1:0] rx_cnt;
    } svr_state_s;

endpackage

//--- hdl/svr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module svr_sync
    import svr_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [`SVR_SYNC_W-1:0] async_in,
    output logic [`SVR_SYNC_W-1:0] sync_out
);

    svr_sync_s s;
    svr_sync_s next_s;

    // First stage feeds only the second stage
    always_comb begin
        next_s.meta = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule // svr_sync

`default_nettype wire

//--- hdl/svr_ctrl.sv
// Function
// - Fixed-enable low: pins decode boot levels
// - Enable rise latches boot level as target
// - Soft-start steps both references together, core only in parallel mode
// - Power-good rises when soft-start completes
// - Enable fall drops power-good, ramps down
// - Fixed-enable high: pins decode fixed levels
// - Fixed mode tracks strap pins unless serial link is monitored
// - Fixed mode soft-starts, then power-good
// - Monitor serial link while running with power-ok high, outside parallel mode
// - Command selects planes and 7-bit code
// - Code maps 1.55 V minus steps; top four off
// - Core plane off keeps power-good high
// - Power-ok low returns to held boot level
// - Power-ok high again waits for command
// - Power-good loss ramps both planes down
// - Enable rise latches mode-select pin
// - Targets after soft-start reached by 3.25 mV/us slew
`timescale 1ns/1ps
`default_nettype none

module svr_ctrl
    import svr_pkg::*;
#(
    parameter int unsigned SS_TOTAL_CYCLES = `SVR_SS_TOTAL_DEFAULT,
    parameter int unsigned SS_STEP_CYCLES = `SVR_SS_STEP_DEFAULT
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic serial_vid_clock_pin_in,
    input wire logic serial_vid_data_pin_in,
    input wire logic enable_in,
    input wire logic fixed_vid_enable_in,
    input wire logic mode_select_pin_in,
    input wire logic processor_power_ok_in,
    input wire logic planes_in_regulation_in,
    output logic [`SVR_LVL_W-1:0] core_plane_ref_out,
    output logic [`SVR_LVL_W-1:0] northbridge_plane_ref_out,
    output logic planes_power_good_out,
    output logic parallel_vid_mode_out,
    output logic soft_start_active_out
);

    localparam logic [`SVR_DWELL_W-1:0] SLEW_LIM =
        `SVR_DWELL_W'(`SVR_SLEW_CYCLES - 1);
    localparam logic [`SVR_DWELL_W-1:0] SS_LIM =
        `SVR_DWELL_W'(SS_STEP_CYCLES - 1);
    localparam logic [`SVR_SS_W-1:0] SS_END =
        `SVR_SS_W'(SS_TOTAL_CYCLES);

    logic [`SVR_SYNC_W-1:0] pins;
    svr_state_s s;
    svr_state_s next_s;

    logic svc;
    logic serial_vid_data_pin;
    logic en;
    logic fix_en;
    logic mode_sel;
    logic pok;
    logic in_reg;
    logic en_rise;
    logic step;
    logic frame_ok;
    logic frame_start;
    logic frame_stop;
    logic [`SVR_LVL_W-1:0] strap_lvl;
    logic [`SVR_LVL_W-1:0] cmd_lvl;
    logic [`SVR_DWELL_W-1:0] dwell_lim;

    // Strap pins and the link both come from the board's clock domain
    svr_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .async_in({planes_in_regulation_in, processor_power_ok_in,
                   mode_select_pin_in, fixed_vid_enable_in, enable_in,
                   serial_vid_data_pin_in, serial_vid_clock_pin_in}),
        .sync_out(pins)
    );

    assign svc = pins[`SVR_SY_CLK];
    assign serial_vid_data_pin = pins[`SVR_SY_DAT];
    assign en = pins[`SVR_SY_EN];
    assign fix_en = pins[`SVR_SY_FIX];
    assign mode_sel = pins[`SVR_SY_SEL];
    assign pok = pins[`SVR_SY_POK];
    assign in_reg = pins[`SVR_SY_REG];

    // Strap decode, boot table or fixed table
    function automatic logic [`SVR_LVL_W-1:0] strap_decode(
        input logic fixed,
        input logic c,
        input logic d
    );
        logic [`SVR_LVL_W-1:0] lvl;
        lvl = `SVR_LVL_ZERO;
        if (fixed) begin
            case ({c, d})
                2'h0: lvl = `SVR_FIX_00;
                2'h1: lvl = `SVR_FIX_01;
                2'h2: lvl = `SVR_FIX_10;
                default: lvl = `SVR_FIX_11;
            endcase
        end else begin
            case ({c, d})
                2'h0: lvl = `SVR_BOOT_00;
                2'h1: lvl = `SVR_BOOT_01;
                2'h2: lvl = `SVR_BOOT_10;
                default: lvl = `SVR_BOOT_11;
            endcase
        end
        return lvl;
    endfunction

    // One level toward the target per step pulse
    function automatic logic [`SVR_LVL_W-1:0] step_toward(
        input logic [`SVR_LVL_W-1:0] cur,
        input logic [`SVR_LVL_W-1:0] tgt
    );
        logic [`SVR_LVL_W-1:0] res;
        res = cur;
        if (cur < tgt) begin
            res = cur + `SVR_LVL_W'(1);
        end else if (cur > tgt) begin
            res = cur - `SVR_LVL_W'(1);
        end
        return res;
    endfunction

    // Data edge while the link clock stays high marks a frame boundary
    function automatic logic link_start(
        input logic c_now,
        input logic c_was,
        input logic d_now,
        input logic d_was
    );
        return c_now && c_was && !d_now && d_was;
    endfunction

    function automatic logic link_stop(
        input logic c_now,
        input logic c_was,
        input logic d_now,
        input logic d_was
    );
        return c_now && c_was && d_now && !d_was;
    endfunction

    assign strap_lvl = strap_decode(fix_en, svc, serial_vid_data_pin);

    // 1.55 V at code 0, 12.5 mV less per code, top four codes off
    assign cmd_lvl = (s.rx_sh[`SVR_LVL_W-1:0] >= `SVR_CODE_OFF) ?
        `SVR_LVL_ZERO : `SVR_LVL_TOP - s.rx_sh[`SVR_LVL_W-1:0];

    assign en_rise = en && !s.en_d;
    assign frame_start = link_start(svc, s.clk_d, serial_vid_data_pin, s.dat_d);
    assign frame_stop = link_stop(svc, s.clk_d, serial_vid_data_pin, s.dat_d);
    // Nine bits, or nine bits and the spacer pulse before the stop
    assign frame_ok = s.rx_on && frame_stop &&
        (s.rx_cnt == `SVR_FRAME_BITS ||
         s.rx_cnt == `SVR_FRAME_BITS + `SVR_CNT_W'(1));

    // Soft-start uses its own dwell, every later move the slew rate
    assign dwell_lim = (s.state == SVR_SOFTSTART) ? SS_LIM : SLEW_LIM;

    always_comb begin
        next_s = s;
        step = 1'b0;
        next_s.en_d = en;
        next_s.clk_d = svc;
        next_s.dat_d = serial_vid_data_pin;

        if (s.dwell >= dwell_lim) begin
            next_s.dwell = '0;
            step = 1'b1;
        end else begin
            next_s.dwell = s.dwell + `SVR_DWELL_W'(1);
        end

        case (s.state)
            SVR_IDLE: begin
                next_s.pgood = 1'b0;
                next_s.rx_on = 1'b0;
                next_s.tgt_core = `SVR_LVL_ZERO;
                next_s.tgt_nb = `SVR_LVL_ZERO;
                if (en_rise) begin
                    next_s.parallel_vid_mode = mode_sel;
                    next_s.hold = strap_lvl;
                    next_s.tgt_core = strap_lvl;
                    // Northbridge regulator is idle in parallel mode
                    next_s.tgt_nb = mode_sel ? `SVR_LVL_ZERO : strap_lvl;
                    next_s.ss_cnt = '0;
                    next_s.dwell = '0;
                    next_s.state = SVR_SOFTSTART;
                end
            end
            SVR_SOFTSTART: begin
                if (!en) begin
                    next_s.state = SVR_IDLE;
                end else begin
                    if (fix_en) begin
                        next_s.tgt_core = strap_lvl;
                        next_s.tgt_nb = s.parallel_vid_mode ? `SVR_LVL_ZERO : strap_lvl;
                    end
                    if (s.ss_cnt < SS_END) begin
                        next_s.ss_cnt = s.ss_cnt + `SVR_SS_W'(1);
                    end else if (s.ref_core == s.tgt_core &&
                                 s.ref_nb == s.tgt_nb && in_reg) begin
                        next_s.pgood = 1'b1;
                        next_s.state = SVR_RUN;
                    end
                end
            end
            SVR_RUN: begin
                if (!en) begin
                    next_s.pgood = 1'b0;
                    next_s.state = SVR_IDLE;
                end else if (!in_reg) begin
                    // Loss of regulation ends the run until enable cycles
                    next_s.pgood = 1'b0;
                    next_s.rx_on = 1'b0;
                    next_s.state = SVR_SHUTDOWN;
                end else if (!pok || s.parallel_vid_mode) begin
                    next_s.rx_on = 1'b0;
                    if (fix_en) begin
                        next_s.tgt_core = strap_lvl;
                        next_s.tgt_nb = s.parallel_vid_mode ? `SVR_LVL_ZERO : strap_lvl;
                    end else begin
                        // Held value only, the pins are not reread
                        next_s.tgt_core = s.hold;
                        next_s.tgt_nb = s.parallel_vid_mode ? `SVR_LVL_ZERO : s.hold;
                    end
                end else begin
                    // Targets stay put until a full frame arrives
                    if (frame_start) begin
                        next_s.rx_on = 1'b1;
                        next_s.rx_cnt = '0;
                        next_s.rx_sh = '0;
                    end else if (frame_ok) begin
                        next_s.rx_on = 1'b0;
                        if (s.rx_sh[`SVR_FR_CORE]) begin
                            next_s.tgt_core = cmd_lvl;
                        end
                        if (s.rx_sh[`SVR_FR_NB]) begin
                            next_s.tgt_nb = cmd_lvl;
                        end
                    end else if (s.rx_on && svc && !s.clk_d) begin
                        if (s.rx_cnt < `SVR_FRAME_BITS) begin
                            next_s.rx_sh = {s.rx_sh[`SVR_FRAME_W-2:0], serial_vid_data_pin};
                            next_s.rx_cnt = s.rx_cnt + `SVR_CNT_W'(1);
                        end else if (s.rx_cnt == `SVR_FRAME_BITS) begin
                            // Spacer lets data drop after a last bit of one
                            next_s.rx_cnt = s.rx_cnt + `SVR_CNT_W'(1);
                        end else begin
                            // Overlong frame is thrown away
                            next_s.rx_on = 1'b0;
                        end
                    end else if (s.rx_on && frame_stop) begin
                        // Short frame ends without effect
                        next_s.rx_on = 1'b0;
                    end
                end
            end
            SVR_SHUTDOWN: begin
                next_s.pgood = 1'b0;
                next_s.tgt_core = `SVR_LVL_ZERO;
                next_s.tgt_nb = `SVR_LVL_ZERO;
                if (!en) begin
                    next_s.state = SVR_IDLE;
                end
            end
            default: begin
                next_s.state = SVR_IDLE;
            end
        endcase

        // Both planes move on the same pulse, never jumping
        if (step) begin
            next_s.ref_core = step_toward(s.ref_core, s.tgt_core);
            next_s.ref_nb = step_toward(s.ref_nb, s.tgt_nb);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign core_plane_ref_out = s.ref_core;
    assign northbridge_plane_ref_out = s.ref_nb;
    assign planes_power_good_out = s.pgood;
    assign parallel_vid_mode_out = s.parallel_vid_mode;
    assign soft_start_active_out = (s.state == SVR_SOFTSTART);

endmodule // svr_ctrl

`default_nettype wire

//--- verification/svr_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "svr_consts.svh"
module svr_ctrl_props #(
    parameter int unsigned SS_TOTAL_CYCLES = 200,
    parameter int unsigned SS_STEP_CYCLES = 2
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic serial_vid_clock_pin_in,
    input wire logic serial_vid_data_pin_in,
    input wire logic enable_in,
    input wire logic fixed_vid_enable_in,
    input wire logic mode_select_pin_in,
    input wire logic processor_power_ok_in,
    input wire logic planes_in_regulation_in,
    input wire logic [`SVR_LVL_W-1:0] core_plane_ref_out,
    input wire logic [`SVR_LVL_W-1:0] northbridge_plane_ref_out,
    input wire logic planes_power_good_out,
    input wire logic parallel_vid_mode_out,
    input wire logic soft_start_active_out
);
    logic [`SVR_LVL_W-1:0] last;
    logic [8:0] gap;
    logic ss_at;
    // First step after reset or soft-start has no slew spacing to keep
    always_ff @(posedge sys_clk_in) begin
        last <= core_plane_ref_out;
        if (!nrst_in || last != core_plane_ref_out) begin
            gap <= 9'h000;
            ss_at <= !nrst_in || soft_start_active_out;
        end else if (gap != 9'h1ff) begin
            gap <= gap + 9'h001;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    reset_zero_a: assert property ($rose(nrst_in) |-> core_plane_ref_out == 0
        && northbridge_plane_ref_out == 0 && !planes_power_good_out)
        else $error("outputs not cleared by reset");
    ss_rise_a: assert property ($rose(enable_in) && !planes_power_good_out
        && core_plane_ref_out == 0 && northbridge_plane_ref_out == 0
        |-> ##[2:4] soft_start_active_out) else $error("no soft-start");
    mode_latch_a: assert property ($rose(soft_start_active_out) |->
        parallel_vid_mode_out == $past(mode_select_pin_in, 4))
        else $error("mode select not latched");
    step_one_a: assert property ($changed(core_plane_ref_out) |->
        core_plane_ref_out == $past(core_plane_ref_out) + 7'h01 ||
        core_plane_ref_out == $past(core_plane_ref_out) - 7'h01)
        else $error("core reference jumped");
    pair_step_a: assert property (soft_start_active_out &&
        !parallel_vid_mode_out && $changed(core_plane_ref_out) |->
        $changed(northbridge_plane_ref_out)) else $error("planes not paired");
    slew_gap_a: assert property ($changed(core_plane_ref_out) &&
        !soft_start_active_out && !ss_at |-> gap >= 9'h180)
        else $error("slew too fast");
    en_fall_pg_a: assert property ($fell(enable_in) |-> ##[1:4]
        !planes_power_good_out) else $error("power good kept after enable");
    pg_after_ss_a: assert property ($rose(planes_power_good_out) |->
        $past(soft_start_active_out) && $past(planes_in_regulation_in, 4))
        else $error("power good without soft-start end");
    reg_loss_a: assert property (planes_power_good_out &&
        !planes_in_regulation_in |-> ##[1:4] !planes_power_good_out)
        else $error("power good kept on regulation loss");
    pg_not_ss_a: assert property (planes_power_good_out |->
        !soft_start_active_out) else $error("power good in soft-start");
endmodule // svr_ctrl_props
bind svr_ctrl svr_ctrl_props #(.SS_TOTAL_CYCLES(SS_TOTAL_CYCLES),
    .SS_STEP_CYCLES(SS_STEP_CYCLES)) props (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .serial_vid_clock_pin_in(serial_vid_clock_pin_in),
    .serial_vid_data_pin_in(serial_vid_data_pin_in), .enable_in(enable_in),
    .fixed_vid_enable_in(fixed_vid_enable_in),
    .mode_select_pin_in(mode_select_pin_in),
    .processor_power_ok_in(processor_power_ok_in),
    .planes_in_regulation_in(planes_in_regulation_in),
    .core_plane_ref_out(core_plane_ref_out),
    .northbridge_plane_ref_out(northbridge_plane_ref_out),
    .planes_power_good_out(planes_power_good_out),
    .parallel_vid_mode_out(parallel_vid_mode_out),
    .soft_start_active_out(soft_start_active_out));
`default_nettype wire

//--- verification/svr_proc_model.sv
`timescale 1ns/1ps
`default_nettype none
module svr_proc_model (
    input wire logic pg_in,
    input wire logic pok_req_in,
    input wire logic [1:0] strap_in,
    output logic clk_pin_out,
    output logic dat_pin_out,
    output logic pok_out
);
    logic busy = 1'b0;
    logic lc;
    logic ld;
    assign pok_out = pok_req_in && pg_in;
    // Straps show on the pins only while power-ok is not requested and no frame is being sent
    assign clk_pin_out = busy ? lc : (pok_req_in | strap_in[1]);
    assign dat_pin_out = busy ? ld : (pok_req_in | strap_in[0]);
    // Link clock only runs inside a frame, 80 ns period
    task automatic send(input logic [8:0] f, input int n);
        busy = 1'b1;
        lc = 1'b1;
        ld = 1'b1;
        #40 ld = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            lc = 1'b0;
            #20 ld = f[i];
            #20 lc = 1'b1;
            #40;
        end
        lc = 1'b0;
        #20 ld = 1'b0;
        #20 lc = 1'b1;
        #40 ld = 1'b1;
        #40 busy = 1'b0;
    endtask
endmodule // svr_proc_model
`default_nettype wire

//--- verification/serial_vid_reference_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "svr_consts.svh"
module serial_vid_reference_control_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic en = 1'b0, fix = 1'b0, sel = 1'b0, pok_req = 1'b0, in_reg = 1'b1;
    logic [1:0] strap = 2'h0;
    logic clk_pin, dat_pin, pok, pg, parallel_vid_mode, ss;
    logic [6:0] core, nb;
    int bad_count = 0, compares = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end
    svr_proc_model pm (.pg_in(pg), .pok_req_in(pok_req), .strap_in(strap),
        .clk_pin_out(clk_pin), .dat_pin_out(dat_pin), .pok_out(pok));
    svr_ctrl #(.SS_TOTAL_CYCLES(200), .SS_STEP_CYCLES(2)) dut (
        .sys_clk_in(sys_clk), .nrst_in(nrst),
        .serial_vid_clock_pin_in(clk_pin), .serial_vid_data_pin_in(dat_pin),
        .enable_in(en), .fixed_vid_enable_in(fix), .mode_select_pin_in(sel),
        .processor_power_ok_in(pok), .planes_in_regulation_in(in_reg),
        .core_plane_ref_out(core), .northbridge_plane_ref_out(nb),
        .planes_power_good_out(pg), .parallel_vid_mode_out(parallel_vid_mode),
        .soft_start_active_out(ss));
    task automatic report_and_stop();
        if (bad_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp_lvl(input logic [6:0] got, input logic [6:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_lvl({6'h00, got}, {6'h00, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic settle(input logic [6:0] c, input logic [6:0] n, input int m);
        for (int i = 0; i < m && (core !== c || nb !== n); i++) cyc(1);
        cmp_lvl(core, c);
        cmp_lvl(nb, n);
    endtask
    task automatic boot(input logic [1:0] s, input logic f, input logic m);
        nrst = 1'b0;
        en = 1'b0;
        pok_req = 1'b0;
        in_reg = 1'b1;
        strap = s;
        fix = f;
        sel = m;
        cyc(4);
        nrst = 1'b1;
        // Mode select stands still for over a microsecond before enable
        cyc(105);
        en = 1'b1;
        for (int i = 0; i < 2000 && pg !== 1'b1; i++) cyc(1);
    endtask
    task automatic t_tables();
        logic [6:0] lv [8] = '{7'h58, 7'h50, 7'h48, 7'h40,
            7'h70, 7'h60, 7'h50, 7'h40};
        for (int i = 0; i < 8; i++) begin
            boot(i[1:0], i[2], 1'b0);
            cmp_bit(pg, 1'b1);
            cmp_bit(ss, 1'b0);
            cmp_bit(parallel_vid_mode, 1'b0);
            settle(lv[i], lv[i], 1);
        end
    endtask
    task automatic t_enfall();
        en = 1'b0;
        cyc(5);
        cmp_bit(pg, 1'b0);
        settle(7'h3e, 7'h3e, 1000);
    endtask
    task automatic t_fixtrack();
        boot(2'h3, 1'b1, 1'b0);
        strap = 2'h2;
        settle(7'h50, 7'h50, 7000);
    endtask
    task automatic t_serial();
        boot(2'h0, 1'b0, 1'b0);
        pok_req = 1'b1;
        cyc(10);
        pm.send(9'h1a5, 9);
        settle(7'h57, 7'h57, 1200);
        pm.send(9'h17c, 9);
        settle(7'h56, 7'h57, 500);
        cmp_bit(pg, 1'b1);
        // Seven bits plus spacer make a short frame
        pm.send(9'h0a6, 7);
        cyc(800);
        cmp_lvl(nb, 7'h57);
        pm.send(9'h0a6, 9);
        cyc(800);
        cmp_lvl(nb, 7'h56);
        pok_req = 1'b0;
        strap = 2'h3;
        settle(7'h58, 7'h58, 4000);
        pok_req = 1'b1;
        cyc(1000);
        settle(7'h58, 7'h58, 1);
        in_reg = 1'b0;
        cyc(5);
        cmp_bit(pg, 1'b0);
        settle(7'h57, 7'h57, 500);
    endtask
    task automatic t_parallel();
        boot(2'h0, 1'b0, 1'b1);
        cmp_bit(parallel_vid_mode, 1'b1);
        pok_req = 1'b1;
        cyc(10);
        pm.send(9'h1a6, 9);
        cyc(800);
        settle(7'h58, 7'h00, 1);
    endtask
    initial begin
        cyc(20);
        t_tables();
        t_enfall();
        t_fixtrack();
        t_serial();
        t_parallel();
        report_and_stop();
    end
endmodule // serial_vid_reference_control_tb_top
`default_nettype wire
